// >>> design/cpmc_reg_store.sv
// Purpose: small register store for the clock control bits
// Assumes: all register values but the status arrive together on wrVal with no write strobe, registered read data
// Notes:   read data appear one cycle after the index is presented
`timescale 1ns/1ps
module cpmc_reg_store
   import cpmc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // write side
   input wire cpmc_regs_t wrVal,
   // read side
   input wire logic [3:0] rdIdx,
   input wire logic [7:0] statVal,
   output logic [7:0] rdData
);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdData <= 8'h00;
      end else begin
         unique case (rdIdx)
            4'h0: rdData <= wrVal.ctl0;
            4'h1: rdData <= wrVal.ctl1;
            4'h2: rdData <= wrVal.ctl2;
            4'h3: rdData <= wrVal.pll;
            4'h4: rdData <= {3'h0, wrVal.main_clock_divide_register};
            4'h5: rdData <= wrVal.pm1;
            4'h6: rdData <= wrVal.prot;
            4'h7: rdData <= statVal;
            default: rdData <= 8'h00;
         endcase
      end
   end

endmodule : cpmc_reg_store

// >>> design/cpmc_top.sv
// Purpose: clock source select, divide, wait/stop modes and write protection
// Assumes: AHB-Lite single word transfers, one clock, inputs synchronous
// Notes:   clock gates and selects are control levels for the clock tree
//
// Notes on behaviour
// - wait mode holds prefetched instructions and halts execution
// - stop mode is refused while the nmi pin is low
// - queued instruction runs before the recovery routine after stop
// - port output and direction state are frozen in wait and stop
// - peripheral stop gates peripheral clocks but sub peripheral clock runs
// - third protect release clears after the next completed write
// - entering stop sets the sub oscillator drive capacity to high
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cpmc_top
   import cpmc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // pins and events
   input wire logic nmiPin_n,
   input wire logic wakeIrq,
   // clock tree controls
   output cpmc_clk_ctl_t clkCtl
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      cpmc_regs_t regs;
      cpmc_mode_t mode;
      logic wrPend;
      logic [3:0] wrIdx;
      logic rdPend;
      logic retire;        // one queued instruction before recovery
      cpmc_clk_ctl_t ctl;
   } cpmc_state_t;

   cpmc_state_t s_q, s_d;
   logic [7:0] rdByte;
   logic [7:0] statVal;

   function automatic logic [3:0] cpmc_index(input logic [7:0] a);
      cpmc_index = (a > CPMC_OFF_CMD || a[1:0] != 2'b00) ? 4'hF : a[5:2];
   endfunction : cpmc_index

   wire logic addrPh = hsel && hready && htrans[1];
   // only a read address phase selects a register; any other cycle loads
   // zero, so the bus shows no stale data between reads
   wire logic [3:0] rdIdx = (addrPh && !hwrite) ? cpmc_index(haddr) : 4'hF;
   assign statVal = {5'h00, s_q.retire, s_q.mode};

   // limitation: a read issued in the data phase of a write to the same
   // register returns the old value, as the store loads at the address
   cpmc_reg_store u_store (
      .clk(clk),
      .arst_n(arst_n),
      .wrVal(s_q.regs),
      .rdIdx(rdIdx),
      .statVal(statVal),
      .rdData(rdByte)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [7:0] w;
      logic unlk0;
      logic unlk1;
      w = hwdata[7:0];
      s_d = s_q;
      unlk0 = s_q.regs.prot[CPMC_B_PRC0];
      unlk1 = s_q.regs.prot[CPMC_B_PRC1] | s_q.regs.prot[CPMC_B_THIRD_PROTECT_RELEASE_BIT];
      s_d.wrPend = addrPh && hwrite;
      s_d.wrIdx = cpmc_index(haddr);
      s_d.rdPend = addrPh && !hwrite;
      s_d.retire = 1'b0;
      if (s_q.wrPend) begin
         // the third_protect_release_bit release lasts for exactly one completed write
         if (s_q.regs.prot[CPMC_B_THIRD_PROTECT_RELEASE_BIT]) begin
            s_d.regs.prot[CPMC_B_THIRD_PROTECT_RELEASE_BIT] = 1'b0;
         end
         unique case (s_q.wrIdx)
            4'h0: if (unlk0) s_d.regs.ctl0 = w;
            4'h1: if (unlk0) s_d.regs.ctl1 = w;
            4'h2: if (unlk0) s_d.regs.ctl2 = w;
            4'h3: if (unlk1) s_d.regs.pll = w;
            4'h4: if (unlk0) s_d.regs.main_clock_divide_register = w[4:0];
            4'h5: if (unlk1) s_d.regs.pm1 = w;
            4'h6: s_d.regs.prot = {5'h00, w[2:0]};
            4'h8: if (w[CPMC_B_CMDWAIT] && s_q.mode == CPMC_RUN) begin
               s_d.mode = CPMC_WAIT;
            end
            default: ;
         endcase
      end
      // a stop request is honoured only while nmi is high
      if (s_d.regs.ctl1[CPMC_B_ALLSTOP]) begin
         s_d.regs.ctl1[CPMC_B_ALLSTOP] = 1'b0;
         if (nmiPin_n && s_q.mode == CPMC_RUN) begin
            s_d.mode = CPMC_STOP;
            s_d.regs.ctl0[CPMC_B_SUBDRV] = 1'b1;
         end
      end
      if (s_q.mode != CPMC_RUN && (wakeIrq || !nmiPin_n)) begin
         s_d.retire = (s_q.mode == CPMC_STOP);
         s_d.mode = CPMC_RUN;
      end
      s_d.ctl.mainRun = !s_d.regs.ctl0[CPMC_B_MSTOP] && s_d.mode != CPMC_STOP;
      s_d.ctl.subDrvHigh = s_d.regs.ctl0[CPMC_B_SUBDRV];
      s_d.ctl.pllOn = s_d.regs.pll[CPMC_B_PLLEN] && s_d.mode != CPMC_STOP;
      s_d.ctl.cpuSrc = s_d.regs.ctl0[CPMC_B_SUBCPU] ? 2'd2 :
                       (s_d.regs.ctl2[CPMC_B_PLLMAIN] ? 2'd1 : 2'd0);
      s_d.ctl.cpuClkEn = s_d.mode == CPMC_RUN;
      s_d.ctl.queueHold = s_d.mode != CPMC_RUN;
      s_d.ctl.periClkEn = s_d.mode == CPMC_RUN || (s_d.mode == CPMC_WAIT
                          && !s_d.regs.ctl0[CPMC_B_PSTOPW]);
      s_d.ctl.subPeriClkEn = s_d.mode != CPMC_STOP;
      s_d.ctl.portHold = s_d.mode != CPMC_RUN;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{regs: '{CPMC_RST_CTL0, CPMC_RST_CTL1, CPMC_RST_CTL2,
                          CPMC_RST_PLL, CPMC_RST_MCD, CPMC_RST_PM1,
                          CPMC_RST_PROT},
                  mode: CPMC_RUN, wrPend: 1'b0, wrIdx: 4'h0,
                  rdPend: 1'b0, retire: 1'b0,
                  ctl: '{1'b1, 1'b1, 1'b0, 2'd0, 1'b1, 1'b1, 1'b1,
                         1'b0, 1'b0}};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         // zero wait states: every register answers in its data phase
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // read data come straight from the store register, loaded at the
   // address phase and zero outside a read data phase
   assign clkCtl = s_q.ctl;
   wire logic [31:0] rdWord = {24'h00_0000, rdByte};
   assign hrdata = rdWord;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_stop_nmi: assert property (
      @(posedge clk) disable iff (!arst_n)
      (s_q.mode != CPMC_STOP && s_d.mode == CPMC_STOP) |-> nmiPin_n)
      else $error("stop entered with nmi low");

   chk_stop_refuse: assert property (
      @(posedge clk) disable iff (!arst_n)
      (s_q.mode == CPMC_RUN && !nmiPin_n) |=> s_q.mode != CPMC_STOP)
      else $error("stop entered while nmi was low");

   chk_prc_clear: assert property (
      @(posedge clk) disable iff (!arst_n)
      (s_q.wrPend && s_q.wrIdx != 4'h6) |=> !s_q.regs.prot[CPMC_B_THIRD_PROTECT_RELEASE_BIT])
      else $error("protect release not cleared");

   chk_stop_drive: assert property (
      @(posedge clk) disable iff (!arst_n)
      $rose(s_q.mode == CPMC_STOP) |-> s_q.regs.ctl0[CPMC_B_SUBDRV])
      else $error("drive not high in stop");

   chk_port_hold: assert property (
      @(posedge clk) disable iff (!arst_n)
      clkCtl.portHold == (s_q.mode != CPMC_RUN))
      else $error("port hold mismatch");

   chk_sub_peri: assert property (
      @(posedge clk) disable iff (!arst_n)
      (s_q.mode == CPMC_WAIT) |-> clkCtl.subPeriClkEn && clkCtl.queueHold)
      else $error("sub clock gated in wait");

   chk_wait_peri: assert property (
      @(posedge clk) disable iff (!arst_n)
      (s_q.mode == CPMC_WAIT && s_q.regs.ctl0[CPMC_B_PSTOPW])
      |-> !clkCtl.periClkEn)
      else $error("peripheral clock ran in wait");

   chk_lock_hold: assert property (
      @(posedge clk) disable iff (!arst_n)
      (s_q.wrPend && s_q.wrIdx == 4'h4 && !s_q.regs.prot[CPMC_B_PRC0])
      |=> $stable(s_q.regs.main_clock_divide_register))
      else $error("locked write changed divide");

   chk_lock_pm1: assert property (
      @(posedge clk) disable iff (!arst_n)
      (s_q.wrPend && s_q.wrIdx == 4'h5 && !s_q.regs.prot[CPMC_B_PRC1]
      && !s_q.regs.prot[CPMC_B_THIRD_PROTECT_RELEASE_BIT]) |=> $stable(s_q.regs.pm1))
      else $error("locked write changed processor mode");

   chk_retire: assert property (
      @(posedge clk) disable iff (!arst_n)
      s_q.retire |-> $past(s_q.mode) == CPMC_STOP)
      else $error("retire without stop exit");

   chk_read_idle: assert property (
      @(posedge clk) disable iff (!arst_n)
      !s_q.rdPend |-> hrdata == 32'h0000_0000)
      else $error("read data outside a read data phase");

endmodule : cpmc_top

// >>> dv/cpmc_far_model.sv
// Purpose: far side model: nmi pin and interrupt source
// Assumes: bench requests are levels, sampled on clk
// Notes:   WAKE_LAT makes the source answer slowly
`timescale 1ns/1ps
module cpmc_far_model
   import cpmc_pkg::*;
#(
   parameter int WAKE_LAT = 3
)
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // bench requests
   input wire logic nmiReq,
   input wire logic wakeReq,
   // pins toward the block
   output logic nmiPin_n,
   output logic wakeIrq
);
   logic [7:0] latCnt_q;

   // pin idles at its pull-up level, low only while requested
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nmiPin_n <= 1'h1;
         wakeIrq <= 1'h0;
         latCnt_q <= 8'h00;
      end else begin
         nmiPin_n <= !nmiReq;
         latCnt_q <= wakeReq ? latCnt_q + 8'h01 : 8'h00;
         wakeIrq <= wakeReq && (latCnt_q >= 8'(WAKE_LAT));
      end
   end
endmodule : cpmc_far_model

// >>> dv/test_clock_power_mode_control.sv
// Purpose: self-checking bench for the clock and power mode control
// Assumes: zero wait state slave, one byte per word in bits 7:0
// Notes:   the far model drives the nmi pin and the wake interrupt
`timescale 1ns/1ps
module test_clock_power_mode_control
   import cpmc_pkg::*;
;
   logic clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic nmiReq, wakeReq, nmiPin_n, wakeIrq;
   cpmc_clk_ctl_t clkCtl;
   int failures = 0;
   int checked = 0;

   assign hready = hreadyout;
   cpmc_top dut_u (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .nmiPin_n(nmiPin_n), .wakeIrq(wakeIrq),
      .clkCtl(clkCtl));
   cpmc_far_model #(.WAKE_LAT(4)) far_u (.clk(clk), .arst_n(arst_n),
      .nmiReq(nmiReq), .wakeReq(wakeReq), .nmiPin_n(nmiPin_n),
      .wakeIrq(wakeIrq));

   // ------
   // tasks
   // ------
   task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t read %h expected %h", $time, got, exp);
      end
   endtask : chkReg

   task automatic chkBit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t control %b expected %b", $time, got, exp);
      end
   endtask : chkBit

   task automatic xfer(input logic wr, input logic [7:0] a,
         input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      // no count assumed: the watchdog ends a hung wait
      @(posedge clk);
      while (hreadyout !== 1'h1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'h1) @(posedge clk);
      rd = hrdata;
      chkBit(hresp, 1'h0);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'h1, a, d);
   endtask : wr

   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0);
      chkReg(rd, e);
   endtask : rdChk

   task automatic modeChk(input cpmc_mode_t m);
      xfer(1'h0, CPMC_OFF_STAT, 32'h0);
      chkReg(rd & 32'h3, 32'(m));
   endtask : modeChk

   task automatic waitHold(input logic v);
      int n;
      n = 0;
      while (clkCtl.portHold !== v && n < 20) begin
         @(posedge clk);
         n++;
      end
      chkBit(clkCtl.portHold, v);
   endtask : waitHold

   // ------
   // scenarios
   // ------
   task automatic resetVals();
      logic [7:0] a [8];
      logic [31:0] e [8];
      a = '{CPMC_OFF_CTL0, CPMC_OFF_CTL1, CPMC_OFF_CTL2, CPMC_OFF_PLL,
         CPMC_OFF_MCD, CPMC_OFF_PM1, CPMC_OFF_PROT, 8'h24};
      e = '{32'(CPMC_RST_CTL0), 32'(CPMC_RST_CTL1), 32'(CPMC_RST_CTL2),
         32'(CPMC_RST_PLL), 32'(CPMC_RST_MCD), 32'(CPMC_RST_PM1),
         32'(CPMC_RST_PROT), 32'h0};
      chkBit(clkCtl.mainRun, 1'h1);
      chkBit(clkCtl.pllOn, 1'h0);
      chkBit(hreadyout, 1'h1);
      for (int i = 0; i < 8; i++) rdChk(a[i], e[i]);
   endtask : resetVals

   task automatic protect();
      wr(CPMC_OFF_CTL0, 32'h04);
      rdChk(CPMC_OFF_CTL0, 32'h08);
      wr(CPMC_OFF_PLL, 32'h80);
      rdChk(CPMC_OFF_PLL, 32'h00);
      wr(CPMC_OFF_PROT, 32'h04);
      wr(CPMC_OFF_PM1, 32'h04);
      rdChk(CPMC_OFF_PM1, 32'h04);
      rdChk(CPMC_OFF_PROT, 32'h00);
      // an unrelated write must also consume the release
      wr(CPMC_OFF_PROT, 32'h04);
      wr(CPMC_OFF_STAT, 32'h00);
      wr(CPMC_OFF_PM1, 32'h00);
      rdChk(CPMC_OFF_PM1, 32'h04);
   endtask : protect

   task automatic stopMode();
      wr(CPMC_OFF_PROT, 32'h01);
      wr(CPMC_OFF_CTL0, 32'h00);
      rdChk(CPMC_OFF_CTL0, 32'h00);
      chkBit(clkCtl.subDrvHigh, 1'h0);
      nmiReq <= 1'h1;
      wr(CPMC_OFF_CTL1, 32'h21);
      modeChk(CPMC_RUN);
      chkBit(clkCtl.portHold, 1'h0);
      nmiReq <= 1'h0;
      wr(CPMC_OFF_CTL1, 32'h21);
      waitHold(1'h1);
      chkBit(clkCtl.subDrvHigh, 1'h1);
      chkBit(clkCtl.cpuClkEn, 1'h0);
      wakeReq <= 1'h1;
      waitHold(1'h0);
      wakeReq <= 1'h0;
      modeChk(CPMC_RUN);
      rdChk(CPMC_OFF_CTL0, 32'h08);
      rdChk(CPMC_OFF_CTL1, 32'h20);
   endtask : stopMode

   task automatic waitMode();
      wr(CPMC_OFF_CTL0, 32'h04);
      wr(CPMC_OFF_CMD, 32'h01);
      repeat (4) @(posedge clk);
      waitHold(1'h1);
      chkBit(clkCtl.periClkEn, 1'h0);
      chkBit(clkCtl.subPeriClkEn, 1'h1);
      chkBit(clkCtl.queueHold, 1'h1);
      modeChk(CPMC_WAIT);
      wakeReq <= 1'h1;
      waitHold(1'h0);
      wakeReq <= 1'h0;
      modeChk(CPMC_RUN);
      chkBit(clkCtl.queueHold, 1'h0);
      chkBit(clkCtl.periClkEn, 1'h1);
   endtask : waitMode

   task automatic divide();
      wr(CPMC_OFF_PROT, 32'h00);
      wr(CPMC_OFF_MCD, 32'h1F);
      rdChk(CPMC_OFF_MCD, 32'(CPMC_RST_MCD));
      wr(CPMC_OFF_PROT, 32'h03);
      wr(CPMC_OFF_PM1, 32'h00);
      rdChk(CPMC_OFF_PM1, 32'h00);
      wr(CPMC_OFF_MCD, 32'h12);
      rdChk(CPMC_OFF_MCD, 32'h12);
      wr(CPMC_OFF_PLL, 32'h80);
      rdChk(CPMC_OFF_PLL, 32'h80);
      chkBit(clkCtl.pllOn, 1'h1);
      // let the pll settle before it feeds the cpu
      repeat (8) @(posedge clk);
      wr(CPMC_OFF_CTL2, 32'h02);
      rdChk(CPMC_OFF_CTL2, 32'h02);
      chkReg(32'(clkCtl.cpuSrc), 32'h1);
      wr(CPMC_OFF_CTL2, 32'h00);
      wr(CPMC_OFF_PLL, 32'h00);
      rdChk(CPMC_OFF_PLL, 32'h00);
      chkBit(clkCtl.pllOn, 1'h0);
      chkReg(32'(clkCtl.cpuSrc), 32'h0);
      // main clock may stop only while the sub clock feeds the cpu; the design does not enforce this, so the bench sets both bits
      wr(CPMC_OFF_CTL0, 32'hA0);
      rdChk(CPMC_OFF_CTL0, 32'hA0);
      chkReg(32'(clkCtl.cpuSrc), 32'h2);
      chkBit(clkCtl.mainRun, 1'h0);
      wr(CPMC_OFF_CTL0, 32'h00);
      rdChk(CPMC_OFF_CTL0, 32'h00);
      chkBit(clkCtl.mainRun, 1'h1);
   endtask : divide

   task automatic nmiStop();
      wr(CPMC_OFF_CTL1, 32'h21);
      waitHold(1'h1);
      nmiReq <= 1'h1;
      waitHold(1'h0);
      nmiReq <= 1'h0;
      modeChk(CPMC_RUN);
      // dummy interrupt between an nmi wake and the next stop
      wakeReq <= 1'h1;
      repeat (6) @(posedge clk);
      wakeReq <= 1'h0;
      wr(CPMC_OFF_CTL1, 32'h21);
      repeat (5) @(posedge clk);
      modeChk(CPMC_STOP);
      // leave stop through reset, held while the oscillator settles
      arst_n <= 1'h0;
      repeat (8) @(posedge clk);
      arst_n <= 1'h1;
      chkBit(clkCtl.portHold, 1'h0);
      modeChk(CPMC_RUN);
      rdChk(CPMC_OFF_PROT, 32'(CPMC_RST_PROT));
      rdChk(CPMC_OFF_MCD, 32'(CPMC_RST_MCD));
   endtask : nmiStop

   task automatic end_sim();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim

   // ------
   // run
   // ------
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   initial begin
      arst_n = 1'h0;
      hsel = 1'h0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      nmiReq = 1'h0;
      wakeReq = 1'h0;
      repeat (5) @(posedge clk);
      arst_n <= 1'h1;
      resetVals();
      protect();
      stopMode();
      waitMode();
      divide();
      nmiStop();
      end_sim();
   end

   // far beyond the few hundred cycles the scenarios need
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      end_sim();
   end
endmodule : test_clock_power_mode_control

// >>> pkg/cpmc_pkg.sv
// Purpose: shared constants and types for the clock and power mode control
// Assumes: AHB-Lite slave with 32-bit data, one word per register
// Notes:   offsets are byte addresses
package cpmc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CPMC_OFF_CTL0 = 8'h00;  // system_clock_control_zero
   localparam logic [7:0] CPMC_OFF_CTL1 = 8'h04;  // system_clock_control_one
   localparam logic [7:0] CPMC_OFF_CTL2 = 8'h08;  // system_clock_control_two
   localparam logic [7:0] CPMC_OFF_PLL = 8'h0C;   // pll_control_zero
   localparam logic [7:0] CPMC_OFF_MCD = 8'h10;   // main_clock_divide_register
   localparam logic [7:0] CPMC_OFF_PM1 = 8'h14;   // processor_mode_one
   localparam logic [7:0] CPMC_OFF_PROT = 8'h18;  // protect release
   localparam logic [7:0] CPMC_OFF_STAT = 8'h1C;  // mode status, read only
   localparam logic [7:0] CPMC_OFF_CMD = 8'h20;   // wait / wake command
   localparam int CPMC_NREG = 9;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CPMC_B_PSTOPW = 2;    // peripheral_stop_in_wait_bit (ctl0)
   localparam int CPMC_B_SUBDRV = 3;    // sub_osc_drive_capacity_bit (ctl0)
   localparam int CPMC_B_MSTOP = 5;     // main_clock_stop_bit (ctl0)
   localparam int CPMC_B_SUBCPU = 7;    // sub_clock_cpu_select_bit (ctl0)
   localparam int CPMC_B_ALLSTOP = 0;   // all_clocks_stop_bit (ctl1)
   localparam int CPMC_B_MAINSUB = 7;   // main_sub_select_bit (ctl1)
   localparam int CPMC_B_PLLMAIN = 1;   // pll_main_select_bit (ctl2)
   localparam int CPMC_B_PLLEN = 7;     // pll_enable_bit (pll)
   localparam int CPMC_B_WAITST = 2;    // wait_state_select_bit (pm1)
   localparam int CPMC_B_PRC0 = 0;      // guards ctl0, ctl1, ctl2 and the divide register
   localparam int CPMC_B_PRC1 = 1;      // guards pm1 and pll
   localparam int CPMC_B_THIRD_PROTECT_RELEASE_BIT = 2;      // third_protect_release_bit
   localparam int CPMC_B_CMDWAIT = 0;   // enter wait mode
   localparam int CPMC_B_CMDWAKE = 1;   // interrupt wakes the core

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CPMC_RST_CTL0 = 8'h08;
   localparam logic [7:0] CPMC_RST_CTL1 = 8'h20;
   localparam logic [7:0] CPMC_RST_CTL2 = 8'h00;
   localparam logic [7:0] CPMC_RST_PLL = 8'h00;
   localparam logic [4:0] CPMC_RST_MCD = 5'h08;
   localparam logic [7:0] CPMC_RST_PM1 = 8'h00;
   localparam logic [7:0] CPMC_RST_PROT = 8'h00;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {CPMC_RUN, CPMC_WAIT, CPMC_STOP} cpmc_mode_t;

   typedef struct packed {
      logic [7:0] ctl0;
      logic [7:0] ctl1;
      logic [7:0] ctl2;
      logic [7:0] pll;
      logic [4:0] main_clock_divide_register;
      logic [7:0] pm1;
      logic [7:0] prot;
   } cpmc_regs_t;

   typedef struct packed {
      logic mainRun;      // main oscillator enable
      logic subDrvHigh;   // sub oscillator drive capacity
      logic pllOn;
      logic [1:0] cpuSrc; // 0 main div, 1 pll div, 2 sub
      logic cpuClkEn;     // cpu clock gate
      logic periClkEn;    // peripheral clock gate
      logic subPeriClkEn; // sub_derived_peripheral_clock gate
      logic portHold;     // freeze port state
      logic queueHold;    // hold prefetched instructions
   } cpmc_clk_ctl_t;

endpackage : cpmc_pkg
